/* core/bsc_pkg.sv */
// Purpose: Shared constants for the start-up and output-level sequencer.
// Assumes: 20 MHz core clock; voltages are held in millivolts.
// Notes:   Pin classes are coded low, open, high, resistor.
package bsc_pkg;
	// Core clock rate in kHz, used to turn milliseconds into cycles.
	localparam int CLK_KHZ = 20000;
	// Memory check time in ms; the upper figure of the quoted window is used.
	localparam int MEM_CHECK_MS = 10;
	localparam int MEM_CHECK_CYC = MEM_CHECK_MS * CLK_KHZ;
	// Fixed minimum pre-ramp delay in ms.
	localparam int MIN_DELAY_MS = 2;
	localparam int MIN_DELAY_CYC = MIN_DELAY_MS * CLK_KHZ;
	// Cycles in one millisecond, the tick of the delay and ramp timers.
	localparam int MS_CYC = CLK_KHZ;
	// Programmable output range in mV.
	localparam logic [12:0] VOUT_MIN_MV = 13'h0258;
	localparam logic [12:0] OUTPUT_CEILING_LIMIT_MV = 13'h1388;
	// Strap targets in mV: low 1.2 V, open 1.5 V, high 3.3 V.
	localparam logic [12:0] STRAP_LOW_MV = 13'h04B0;
	localparam logic [12:0] STRAP_OPEN_MV = 13'h05DC;
	localparam logic [12:0] STRAP_HIGH_MV = 13'h0CE4;
	// Soft-start strap times in ms: low 2, open 5, high 10.
	localparam logic [7:0] SS_LOW_MS = 8'h02;
	localparam logic [7:0] SS_OPEN_MS = 8'h05;
	localparam logic [7:0] SS_HIGH_MS = 8'h0A;
	// Number of resistor codes for the output level pin (10 k to 178 k).
	localparam int RES_CODES = 31;
	// Multi-mode pin classification.
	typedef enum logic [1:0] {
		PIN_LOW  = 2'b00,
		PIN_OPEN = 2'b01,
		PIN_HIGH = 2'b10,
		PIN_RES  = 2'b11
	} bsc_pin_t;
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_POWER = 3'b000,
		ST_MEM   = 3'b001,
		ST_PINS  = 3'b010,
		ST_READY = 3'b011,
		ST_DELAY = 3'b100,
		ST_RAMP  = 3'b101,
		ST_ON    = 3'b110
	} bsc_state_t;
endpackage

/* core/bsc_vout_decode.sv */
// Purpose: Maps the output level pin class and resistor code to a target voltage.
// Assumes: Resistor code 0 is 10 k and code 30 is 178 k.
// Notes:   Pure combinational lookup; codes above 30 fall back to the lowest level.
`timescale 1ns/1ps
module bsc_vout_decode (
	input  wire logic [1:0] pinClass,
	input  wire logic [4:0] resCode,
	output logic      [12:0] targetMv
);
	// Resistor lookup table in millivolts, code 0 first.
	localparam logic [12:0] RES_MV [0:30] = '{
		13'h0258, 13'h02BC, 13'h02EE, 13'h0320, 13'h0384, 13'h03E8, 13'h044C,
		13'h04B0, 13'h04E2, 13'h0514, 13'h0578, 13'h05DC, 13'h0640, 13'h06A4,
		13'h0708, 13'h076C, 13'h07D0, 13'h0834, 13'h0898, 13'h08FC, 13'h0960,
		13'h09C4, 13'h0A28, 13'h0A8C, 13'h0AF0, 13'h0B54, 13'h0BB8, 13'h0C1C,
		13'h0C80, 13'h0CE4, 13'h1388
	};

	// Strap or resistor decode of the output level select pin.
	always_comb begin
		unique case (pinClass)
			// RULE_01: strap level decode
			bsc_pkg::PIN_LOW:  targetMv = bsc_pkg::STRAP_LOW_MV;
			bsc_pkg::PIN_OPEN: targetMv = bsc_pkg::STRAP_OPEN_MV;
			bsc_pkg::PIN_HIGH: targetMv = bsc_pkg::STRAP_HIGH_MV;
			// RULE_02: resistor code lookup
			default: begin
				if (resCode < 5'(bsc_pkg::RES_CODES)) begin
					targetMv = RES_MV[resCode];
				end else begin
					targetMv = bsc_pkg::VOUT_MIN_MV;
				end
			end
		endcase
	end
endmodule

/* core/bsc_sequencer.sv */
// Purpose: Power-up configuration load, ready, pre-ramp delay and soft-start ramp control.
// Assumes: Pin classes come from an analog front end and are asynchronous.
// Notes:   Management bus writes arrive as a decoded strobe from the bus engine.
`timescale 1ns/1ps
// What this block does
// RULE_01: Strap low/open/high gives 1.2/1.5/3.3 V.
// RULE_02: Resistor code maps through voltage lookup.
// RULE_03: Bus-programmed target overrides the strap.
// RULE_04: Memory check lasts about ten ms.
// RULE_05: Stored values load during memory check.
// RULE_06: Restore repeats check and pin load.
// RULE_07: After check, sample all configuration pins.
// RULE_08: Ignore enable and bus while loading.
// RULE_09: Ready state accepts bus and enable.
// RULE_10: Wait about two ms after enable.
// RULE_11: Shorter delay is raised to two ms.
// RULE_12: Longer delay is honoured in full.
// RULE_13: Soft-start pin selects extra delay.
// RULE_14: Ramp to target over ramp time.
// RULE_15: Tied enable still waits for configuration.
// RULE_16: External clock stable before enable.
// RULE_17: Pins sampled only at power or restore.
// RULE_18: Pins classify as low, open, high.
// RULE_19: Ceiling is ten percent above level.
// RULE_20: Enable drop in delay returns to ready.
// RULE_21: Switching stays off before the ramp.
module bsc_sequencer #(
	parameter int MEM_CYC = bsc_pkg::MEM_CHECK_CYC,
	parameter int MIN_CYC = bsc_pkg::MIN_DELAY_CYC,
	parameter int TICK_CYC = bsc_pkg::MS_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        enablePin,
	input  wire logic [1:0]  levelPinClass,
	input  wire logic [4:0]  levelResCode,
	input  wire logic [1:0]  ssPinClass,
	input  wire logic        restoreCmd,
	input  wire logic        nvmValid,
	input  wire logic [12:0] nvmVoutMv,
	input  wire logic [7:0]  nvmDelayMs,
	input  wire logic [7:0]  nvmRampMs,
	input  wire logic        busWrVout,
	input  wire logic        busWrDelay,
	input  wire logic        busWrRamp,
	input  wire logic [12:0] busData,
	output logic             busAccept,
	output logic             ready,
	output logic             switchEnable,
	output logic             rampActive,
	output logic [12:0]      targetMv,
	output logic [12:0]      rampMv,
	output logic [13:0]      ceilingMv
);
	// Two-stage synchronisers for enable and pin classes.
	logic [4:0] syncA_reg;
	logic [4:0] syncB_reg;
	logic       enS;
	logic [1:0] levelS;
	logic [1:0] ssS;
	assign enS = syncB_reg[0];
	assign levelS = syncB_reg[2:1];
	assign ssS = syncB_reg[4:3];

	// Resistor code passes through its own two-stage register; its value is used only in pin sampling.
	logic [4:0] resS1_reg;
	logic [4:0] resS2_reg;

	// Synchroniser registers; the first stage is read only by the second.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= 5'h00;
			syncB_reg <= 5'h00;
			resS1_reg <= 5'h00;
			resS2_reg <= 5'h00;
		end else begin
			syncA_reg <= {ssPinClass, levelPinClass, enablePin};
			syncB_reg <= syncA_reg;
			resS1_reg <= levelResCode;
			resS2_reg <= resS1_reg;
		end
	end

	// Decoded strap or resistor level, used only when pins are sampled.
	logic [12:0] pinMv;
	bsc_vout_decode uDecode (
		.pinClass (levelS),
		.resCode  (resS2_reg),
		.targetMv (pinMv)
	);

	// Sequencer state and configuration.
	bsc_pkg::bsc_state_t state_reg, state_next;
	logic [21:0] cnt_reg, cnt_next;        // Cycle counter for timed phases.
	logic [14:0] tick_reg, tick_next;      // Millisecond prescaler.
	logic [7:0]  msCnt_reg, msCnt_next;    // Elapsed milliseconds.
	logic [12:0] target_reg, target_next;  // Applied target voltage.
	logic [12:0] strap_reg, strap_next;    // Level pin voltage, for the ceiling.
	logic [12:0] ramp_reg, ramp_next;      // Present ramp setpoint.
	logic [7:0]  delay_reg, delay_next;    // Configured soft-start delay in ms.
	logic [7:0]  rampMs_reg, rampMs_next;  // Configured ramp time in ms.
	logic        nvmVout_reg, nvmVout_next; // Stored voltage overrides the pins.
	logic        nvmSs_reg, nvmSs_next;     // Stored timing overrides the pins.
	logic        minDone;
	logic        msTick;
	logic [12:0] stepMv;

	assign msTick = (tick_reg == 15'(TICK_CYC - 1));
	assign minDone = (cnt_reg >= 22'(MIN_CYC - 1));
	// Ramp step per millisecond; a zero ramp time jumps straight to target.
	assign stepMv = (rampMs_reg == 8'h00) ? target_reg : 13'(target_reg / rampMs_reg);

	// Next-state logic for the whole sequence.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 22'h000001;
		tick_next = msTick ? 15'h0000 : tick_reg + 15'h0001;
		msCnt_next = msTick ? msCnt_reg + 8'h01 : msCnt_reg;
		target_next = target_reg;
		strap_next = strap_reg;
		ramp_next = ramp_reg;
		delay_next = delay_reg;
		rampMs_next = rampMs_reg;
		nvmVout_next = nvmVout_reg;
		nvmSs_next = nvmSs_reg;
		// RULE_06: restore restarts loading
		if (restoreCmd && state_reg != bsc_pkg::ST_MEM && state_reg != bsc_pkg::ST_PINS) begin
			state_next = bsc_pkg::ST_MEM;
			cnt_next = 22'h000000;
			ramp_next = 13'h0000;
			nvmVout_next = 1'b0;
			nvmSs_next = 1'b0;
		end else begin
			unique case (state_reg)
				bsc_pkg::ST_POWER: begin
					state_next = bsc_pkg::ST_MEM;
					cnt_next = 22'h000000;
				end
				bsc_pkg::ST_MEM: begin
					// RULE_05: load stored values
					if (nvmValid) begin
						target_next = nvmVoutMv;
						delay_next = nvmDelayMs;
						rampMs_next = nvmRampMs;
						nvmVout_next = 1'b1;
						nvmSs_next = 1'b1;
					end
					// RULE_04: memory check time
					if (cnt_reg >= 22'(MEM_CYC - 1)) begin
						state_next = bsc_pkg::ST_PINS;
					end
				end
				bsc_pkg::ST_PINS: begin
					// RULE_07: sample config pins
					// RULE_17: only sampled here
					strap_next = pinMv;
					if (!nvmVout_reg) begin
						target_next = pinMv;
					end
					// RULE_13: soft-start pin timing
					// RULE_18: three-state pin classes
					if (!nvmSs_reg) begin
						unique case (ssS)
							bsc_pkg::PIN_LOW:  delay_next = bsc_pkg::SS_LOW_MS;
							bsc_pkg::PIN_HIGH: delay_next = bsc_pkg::SS_HIGH_MS;
							default:           delay_next = bsc_pkg::SS_OPEN_MS;
						endcase
						rampMs_next = delay_next;
					end
					state_next = bsc_pkg::ST_READY;
				end
				bsc_pkg::ST_READY: begin
					// RULE_09: respond to enable
					// RULE_15: enable start only seen here
					if (enS) begin
						state_next = bsc_pkg::ST_DELAY;
						cnt_next = 22'h000000;
						tick_next = 15'h0000;
						msCnt_next = 8'h00;
					end
				end
				bsc_pkg::ST_DELAY: begin
					// RULE_20: abort on enable loss
					if (!enS) begin
						state_next = bsc_pkg::ST_READY;
					// RULE_10: fixed minimum wait
					// RULE_11: floor at two ms
					// RULE_12: full longer delay
					end else if (minDone && msCnt_reg >= delay_reg) begin
						state_next = bsc_pkg::ST_RAMP;
						tick_next = 15'h0000;
						ramp_next = 13'h0000;
					end
				end
				bsc_pkg::ST_RAMP: begin
					// RULE_14: step toward target
					if (!enS) begin
						state_next = bsc_pkg::ST_READY;
						ramp_next = 13'h0000;
					// The sum is widened so a high stored target cannot wrap past it.
					end else if (rampMs_reg == 8'h00 || (msTick
					    && 14'(ramp_reg) + 14'(stepMv) >= 14'(target_reg))) begin
						ramp_next = target_reg;
						state_next = bsc_pkg::ST_ON;
					end else if (msTick) begin
						ramp_next = ramp_reg + stepMv;
					end
				end
				bsc_pkg::ST_ON: begin
					ramp_next = target_reg;
					if (!enS) begin
						state_next = bsc_pkg::ST_READY;
						ramp_next = 13'h0000;
					end
				end
				default: state_next = bsc_pkg::ST_POWER;
			endcase
			// RULE_08: bus ignored while loading
			// RULE_03: bus target override
			if (busAccept && busWrVout && busData >= bsc_pkg::VOUT_MIN_MV
			    && busData <= bsc_pkg::OUTPUT_CEILING_LIMIT_MV) begin
				target_next = busData;
			end
			if (busAccept && busWrDelay) begin
				delay_next = busData[7:0];
			end
			if (busAccept && busWrRamp) begin
				rampMs_next = busData[7:0];
			end
		end
	end

	// State registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= bsc_pkg::ST_POWER;
			cnt_reg <= 22'h000000;
			tick_reg <= 15'h0000;
			msCnt_reg <= 8'h00;
			target_reg <= bsc_pkg::STRAP_OPEN_MV;
			strap_reg <= bsc_pkg::STRAP_OPEN_MV;
			ramp_reg <= 13'h0000;
			delay_reg <= bsc_pkg::SS_OPEN_MS;
			rampMs_reg <= bsc_pkg::SS_OPEN_MS;
			nvmVout_reg <= 1'b0;
			nvmSs_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
			msCnt_reg <= msCnt_next;
			target_reg <= target_next;
			strap_reg <= strap_next;
			ramp_reg <= ramp_next;
			delay_reg <= delay_next;
			rampMs_reg <= rampMs_next;
			nvmVout_reg <= nvmVout_next;
			nvmSs_reg <= nvmSs_next;
		end
	end

	// Bus acceptance follows state directly; a handshake may be combinational.
	assign busAccept = (state_reg == bsc_pkg::ST_READY) || (state_reg == bsc_pkg::ST_DELAY)
	                || (state_reg == bsc_pkg::ST_RAMP) || (state_reg == bsc_pkg::ST_ON);
	assign ready = (state_reg == bsc_pkg::ST_READY);
	// RULE_21: switching off before ramp
	assign switchEnable = (state_reg == bsc_pkg::ST_RAMP) || (state_reg == bsc_pkg::ST_ON);
	assign rampActive = (state_reg == bsc_pkg::ST_RAMP);
	assign targetMv = target_reg;
	assign rampMv = ramp_reg;
	// RULE_19: ceiling ten percent up
	assign ceilingMv = 14'(strap_reg) + 14'(strap_reg / 13'h000A);
endmodule

/* testbench/bsc_seq_checker.sv */
// Purpose: Port checks on the start-up sequencer.
// Assumes: Counts match the bound instance.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module bsc_seq_checker #(
	parameter int MEM_CYC = 20,
	parameter int MIN_CYC = 10
) (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        enablePin,
	input wire logic        restoreCmd,
	input wire logic        busWrVout,
	input wire logic [12:0] busData,
	input wire logic        busAccept,
	input wire logic        ready,
	input wire logic        switchEnable,
	input wire logic        rampActive,
	input wire logic [12:0] targetMv,
	input wire logic [12:0] rampMv
);
	// Run lengths of a closed bus and of a high enable; both saturate.
	int lowCnt_reg;
	int enCnt_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lowCnt_reg <= 0;
			enCnt_reg <= 0;
		end else begin
			lowCnt_reg <= busAccept ? 0 : lowCnt_reg + int'(lowCnt_reg < 999);
			enCnt_reg <= enablePin ? enCnt_reg + int'(enCnt_reg < 99999) : 0;
		end
	end
	sequence enFall;
		$fell(enablePin);
	endsequence
	sequence swOff;
		!switchEnable;
	endsequence
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_ready_no_sw: assert property (ready |-> !switchEnable)
		else $error("switching in ready");
	a_sw_open: assert property (switchEnable |-> busAccept)
		else $error("switching while loading");
	a_ramp_sw: assert property (rampActive |-> switchEnable)
		else $error("ramp without switching");
	a_en_drop: assert property (enFall |-> ##[1:5] swOff)
		else $error("enable drop kept switching");
	a_ready_zero: assert property (ready |-> rampMv == 13'h0000)
		else $error("ramp level left in ready");
	a_vout_take: assert property (busWrVout && busAccept && !restoreCmd && busData >= 13'h0258
		&& busData <= 13'h1388 |=> targetMv == $past(busData))
		else $error("level write lost");
	a_vout_skip: assert property (busWrVout && busAccept && !restoreCmd && (busData < 13'h0258
		|| busData > 13'h1388) |=> $stable(targetMv))
		else $error("bad level taken");
	a_delay_min: assert property ($rose(switchEnable) |-> enCnt_reg >= MIN_CYC + 3)
		else $error("ramp before minimum delay");
	a_mem_len: assert property ($rose(busAccept) |-> lowCnt_reg >= MEM_CYC
		&& lowCnt_reg <= MEM_CYC + 2)
		else $error("load phase length wrong");
endmodule

/* testbench/bsc_host_model.sv */
// Purpose: Host that drives enable and management writes.
// Assumes: Writes are one-cycle strobes launched at the falling edge.
// Notes:   Released data shows its inverse so stale data never matches.
`timescale 1ns/1ps
module bsc_host_model (
	input  wire logic        core_clk,
	output logic             enablePin,
	output logic             busWrVout,
	output logic             busWrDelay,
	output logic             busWrRamp,
	output logic [12:0]      busData
);
	initial begin
		enablePin = 1'b0;
		busWrVout = 1'b0;
		busWrDelay = 1'b0;
		busWrRamp = 1'b0;
		busData = 13'h0000;
	end
	// clock runs first: enable only moves once the clock is running.
	task automatic setEnable(input logic v);
		@(negedge core_clk);
		enablePin = v;
	endtask
	// bus writes: kind 0 level, 1 delay, 2 ramp.
	task automatic write(input int kind, input logic [12:0] d);
		@(negedge core_clk);
		busData = d;
		busWrVout = (kind == 0);
		busWrDelay = (kind == 1);
		busWrRamp = (kind == 2);
		@(negedge core_clk);
		busWrVout = 1'b0;
		busWrDelay = 1'b0;
		busWrRamp = 1'b0;
		busData = ~d;
	endtask
endmodule

/* testbench/test_buck_startup_config_sequencer.sv */
// Purpose: Self-checking bench for the start-up sequencer.
// Assumes: Short counts: load 20, minimum delay 10, tick 5 cycles.
// Notes:   Expectations come from a small integer model.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_buck_startup_config_sequencer;
	localparam int MEM_CYC = 20;
	localparam int MIN_CYC = 10;
	localparam int TICK_CYC = 5;
	logic        core_clk = 1'b0, arst_n, restoreCmd, nvmValid, enablePin, busWrVout, busWrDelay;
	logic        busWrRamp, busAccept, ready, switchEnable, rampActive;
	logic [1:0]  levelPinClass, ssPinClass;
	logic [4:0]  levelResCode, rc;
	logic [12:0] nvmVoutMv, targetMv, rampMv, busData;
	logic [7:0]  nvmDelayMs, nvmRampMs;
	logic [13:0] ceilingMv;
	logic [15:0] rnd;
	int          n_mismatch, samples_checked, expT, expC, expD, expR, cyc, i;
	// Resistor code to level in mV.
	int resTab[31] = '{600, 700, 750, 800, 900, 1000, 1100, 1200, 1250, 1300, 1400, 1500,
		1600, 1700, 1800, 1900, 2000, 2100, 2200, 2300, 2400, 2500, 2600, 2700, 2800, 2900,
		3000, 3100, 3200, 3300, 5000};
	bsc_host_model host (.core_clk(core_clk), .enablePin(enablePin), .busWrVout(busWrVout),
		.busWrDelay(busWrDelay), .busWrRamp(busWrRamp), .busData(busData));
	bsc_sequencer #(.MEM_CYC(MEM_CYC), .MIN_CYC(MIN_CYC), .TICK_CYC(TICK_CYC)) uut (
		.core_clk(core_clk), .arst_n(arst_n), .enablePin(enablePin),
		.levelPinClass(levelPinClass), .levelResCode(levelResCode), .ssPinClass(ssPinClass),
		.restoreCmd(restoreCmd), .nvmValid(nvmValid), .nvmVoutMv(nvmVoutMv),
		.nvmDelayMs(nvmDelayMs), .nvmRampMs(nvmRampMs), .busWrVout(busWrVout),
		.busWrDelay(busWrDelay), .busWrRamp(busWrRamp), .busData(busData),
		.busAccept(busAccept), .ready(ready), .switchEnable(switchEnable),
		.rampActive(rampActive), .targetMv(targetMv), .rampMv(rampMv), .ceilingMv(ceilingMv));
	function automatic int strapMv(input logic [1:0] c, input logic [4:0] r);
		if (c == bsc_pkg::PIN_RES) return (r > 30) ? 600 : resTab[r];
		return (c == bsc_pkg::PIN_LOW) ? 1200 : (c == bsc_pkg::PIN_HIGH) ? 3300 : 1500;
	endfunction
	function automatic int ssMs(input logic [1:0] c);
		return (c == bsc_pkg::PIN_LOW) ? 2 : (c == bsc_pkg::PIN_HIGH) ? 10 : 5;
	endfunction
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
	endfunction
	task automatic waitReady();
		cyc = 0;
		while (ready !== 1'b1 && cyc < 300) begin
			@(negedge core_clk);
			cyc++;
		end
	endtask
	// Pins are set well before the pin phase, so the double sync has settled.
	task automatic restore(input logic [1:0] lc, input logic [4:0] r, input logic [1:0] sc,
		input logic nv);
		host.setEnable(1'b0);
		levelPinClass = lc;
		levelResCode = r;
		ssPinClass = sc;
		nvmValid = nv;
		repeat (4) @(negedge core_clk);
		restoreCmd = 1'b1;
		@(negedge core_clk);
		restoreCmd = 1'b0;
		waitReady();
		expC = strapMv(lc, r) + strapMv(lc, r) / 10;
		expT = nv ? int'(nvmVoutMv) : strapMv(lc, r);
		expD = nv ? int'(nvmDelayMs) : ssMs(sc);
		expR = nv ? int'(nvmRampMs) : ssMs(sc);
		`CHK(ready, 1'b1)
		`CHK(targetMv, 13'(expT))
		`CHK(ceilingMv, 14'(expC))
	endtask
	// Enable from ready, then time the delay and the ramp against the model.
	task automatic run();
		int d;
		int r;
		d = (expD * TICK_CYC > MIN_CYC) ? expD * TICK_CYC : MIN_CYC;
		r = expR * TICK_CYC;
		host.setEnable(1'b1);
		cyc = 0;
		while (switchEnable !== 1'b1 && cyc < 3000) begin
			@(negedge core_clk);
			cyc++;
		end
		`CHK(cyc >= d + 2 && cyc <= d + 5, 1'b1)
		cyc = 0;
		while (rampActive === 1'b1 && cyc < 3000) begin
			@(negedge core_clk);
			cyc++;
		end
		`CHK(cyc + TICK_CYC >= r && cyc <= r + TICK_CYC + 2, 1'b1)
		`CHK(rampMv, 13'(expT))
	endtask
	task end_of_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// The clock starts low by its initialiser, so no false falling edge at time zero.
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#2000000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		arst_n = 1'b0;
		restoreCmd = 1'b0;
		nvmValid = 1'b0;
		levelPinClass = 2'b00;
		levelResCode = 5'h00;
		ssPinClass = 2'b00;
		nvmVoutMv = 13'h0000;
		nvmDelayMs = 8'h00;
		nvmRampMs = 8'h00;
		n_mismatch = 0;
		samples_checked = 0;
		rnd = 16'hB6FB;
		// Enable tied high from power-up; a write lands in the load phase.
		host.setEnable(1'b1);
		repeat (19) @(negedge core_clk);
		`CHK(targetMv, 13'h05DC)
		arst_n = 1'b1;
		host.write(0, 13'h07D0);
		waitReady();
		`CHK(cyc >= MEM_CYC - 1 && cyc <= MEM_CYC + 2, 1'b1)
		`CHK(targetMv, 13'h04B0)
		`CHK(switchEnable, 1'b0)
		repeat (30) @(negedge core_clk);
		`CHK(switchEnable, 1'b1)
		// Bus writes: the top range end, two refusals, zero delay and ramp.
		host.setEnable(1'b0);
		repeat (4) @(negedge core_clk);
		host.write(1, 13'h0000);
		host.write(2, 13'h0000);
		host.write(0, 13'h1388);
		host.write(0, 13'h1389);
		host.write(0, 13'h0257);
		`CHK(targetMv, 13'h1388)
		`CHK(ceilingMv, 14'h0528)
		expT = 5000;
		expD = 0;
		expR = 0;
		run();
		// Enable dropped inside the delay abandons the ramp.
		host.setEnable(1'b0);
		repeat (4) @(negedge core_clk);
		host.setEnable(1'b1);
		repeat (6) @(negedge core_clk);
		host.setEnable(1'b0);
		repeat (4) @(negedge core_clk);
		`CHK(ready, 1'b1)
		repeat (60) @(negedge core_clk);
		`CHK(switchEnable, 1'b0)
		// Every level class and soft-start class, with resistor codes 30 and 31 and random codes.
		for (i = 0; i < 7; i++) begin
			rnd = lfsr(rnd);
			rc = (i == 3) ? 5'h1E : (i == 4) ? 5'h1F : 5'(rnd % 31);
			restore((i < 3) ? 2'(i) : 2'b11, rc, 2'(i), 1'b0);
			run();
		end
		// A pin change without a restore is not picked up.
		levelPinClass = levelPinClass ^ 2'b01;
		repeat (10) @(negedge core_clk);
		`CHK(targetMv, 13'(expT))
		// Stored values are random within the programmable range, ramp 1 to 8 ms.
		rnd = lfsr(rnd);
		nvmVoutMv = 13'(600 + int'(rnd) % 4401);
		nvmDelayMs = 8'(rnd[3:0]);
		nvmRampMs = 8'(1 + int'(rnd[6:4]));
		restore(2'(rnd[9:8]), 5'(rnd[14:10] % 31), 2'(rnd[12:11]), 1'b1);
		run();
		end_of_test();
	end
endmodule
bind bsc_sequencer bsc_seq_checker #(.MEM_CYC(MEM_CYC), .MIN_CYC(MIN_CYC)) chk (
	.core_clk(core_clk), .arst_n(arst_n), .enablePin(enablePin), .restoreCmd(restoreCmd),
	.busWrVout(busWrVout), .busData(busData), .busAccept(busAccept), .ready(ready),
	.switchEnable(switchEnable), .rampActive(rampActive), .targetMv(targetMv), .rampMv(rampMv));
